/* design/gpb_pkg.sv */
package gpb_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PORT_W    = 8;
  localparam int BUS_W     = 32;
  localparam int OFS_W     = 8;
  localparam int HADDR_PIN = 4;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_H_PIN  = 8'h00;
  localparam logic [7:0] OFS_H_LAT  = 8'h04;
  localparam logic [7:0] OFS_H_DIR  = 8'h08;
  localparam logic [7:0] OFS_J_PIN  = 8'h0C;
  localparam logic [7:0] OFS_J_LAT  = 8'h10;
  localparam logic [7:0] OFS_J_DIR  = 8'h14;
  localparam logic [7:0] OFS_PU_CTL = 8'h18;
  localparam logic [7:0] OFS_MEMCTL = 8'h1C;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int         PU_BIT      = 5;
  localparam int         EXT_BUS_DISABLE_BIT   = 7;
  localparam logic [7:0] LAT_RST     = 8'h00;
  localparam logic [7:0] DIR_RST     = 8'hFF;
  localparam logic       PU_RST      = 1'b0;
  localparam logic       EXT_BUS_DISABLE_RST   = 1'b1;
  localparam logic [7:0] H_ADDR_MASK = 8'h0F;
  localparam logic [7:0] ALL_MASK    = 8'hFF;
  localparam logic [7:0] NONE_MASK   = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RD   = 2'b10
  } gpb_bus_st_t;

  typedef struct packed {
    logic [PORT_W-1:0] data;
    logic [PORT_W-1:0] oe_n;
  } gpb_pins_t;

endpackage

/* design/gpb_ports.sv */
`timescale 1ns/100ps
module gpb_ports (
  input  wire logic                         SYS_CLK,
  input  wire logic                         NRST,
  input  wire logic                         HSEL,
  input  wire logic [gpb_pkg::BUS_W-1:0]    HADDR,
  input  wire logic [1:0]                   HTRANS,
  input  wire logic                         HWRITE,
  input  wire logic [2:0]                   HSIZE,
  input  wire logic [gpb_pkg::BUS_W-1:0]    HWDATA,
  input  wire logic                         HREADY,
  output logic      [gpb_pkg::BUS_W-1:0]    HRDATA,
  output logic                              HREADYOUT,
  output logic                              HRESP,
  input  wire logic [gpb_pkg::PORT_W-1:0]   PORT_H_PIN_IN,
  output gpb_pkg::gpb_pins_t                PORT_H_PINS,
  input  wire logic [gpb_pkg::PORT_W-1:0]   PORT_J_PIN_IN,
  output gpb_pkg::gpb_pins_t                PORT_J_PINS,
  output logic      [gpb_pkg::PORT_W-1:0]   PORT_J_PULLUP_EN,
  input  wire logic [gpb_pkg::HADDR_PIN-1:0] HIGH_ADDRESS_IN,
  input  wire logic [gpb_pkg::PORT_W-1:0]   BUS_CTRL_IN,
  output logic                              EXT_BUS_ENABLE
);
  import gpb_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  gpb_bus_st_t       st_q,     st_d;
  logic [OFS_W-1:0]  addr_q,   addr_d;
  logic              wr_pend_q, wr_pend_d;
  logic [BUS_W-1:0]  rdata_q,  rdata_d;
  logic              ready_q,  ready_d;
  logic [PORT_W-1:0] lat_h_q,  lat_h_d;
  logic [PORT_W-1:0] dir_h_q,  dir_h_d;
  logic [PORT_W-1:0] lat_j_q,  lat_j_d;
  logic [PORT_W-1:0] dir_j_q,  dir_j_d;
  logic              pu_q,     pu_d;
  logic              ext_bus_disable_q,  ext_bus_disable_d;
  gpb_pins_t         h_pins_q, h_pins_d;
  gpb_pins_t         j_pins_q, j_pins_d;
  logic [PORT_W-1:0] pullup_q, pullup_d;
  logic              bus_en_q, bus_en_d;
  logic              emi_en;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic gpb_pins_t pin_mux(input logic [PORT_W-1:0] ovr,
                                        input logic [PORT_W-1:0] alt,
                                        input logic [PORT_W-1:0] lat,
                                        input logic [PORT_W-1:0] dir);
    gpb_pins_t p;
    p.data = (ovr & alt) | (~ovr & lat);
    p.oe_n = ~ovr & dir;
    return p;
  endfunction

  function automatic logic [BUS_W-1:0] widen(input logic [PORT_W-1:0] v);
    return {{(BUS_W-PORT_W){1'b0}}, v};
  endfunction

  assign emi_en = ~ext_bus_disable_q;

  // ----------------------------------------
  // AHB-Lite slave and registers
  // ----------------------------------------
  always_comb begin
    st_d      = st_q;
    addr_d    = addr_q;
    wr_pend_d = 1'b0;
    rdata_d   = rdata_q;
    ready_d   = 1'b1;
    lat_h_d   = lat_h_q;
    dir_h_d   = dir_h_q;
    lat_j_d   = lat_j_q;
    dir_j_d   = dir_j_q;
    pu_d      = pu_q;
    ext_bus_disable_d   = ext_bus_disable_q;
    // Write commits at end of its zero-wait data phase
    if (wr_pend_q) begin
      case (addr_q)
        OFS_H_PIN:  lat_h_d = HWDATA[PORT_W-1:0];
        OFS_H_LAT:  lat_h_d = HWDATA[PORT_W-1:0];
        OFS_H_DIR:  dir_h_d = HWDATA[PORT_W-1:0];
        OFS_J_PIN:  lat_j_d = HWDATA[PORT_W-1:0];
        OFS_J_LAT:  lat_j_d = HWDATA[PORT_W-1:0];
        OFS_J_DIR:  dir_j_d = HWDATA[PORT_W-1:0];
        OFS_PU_CTL: pu_d = HWDATA[PU_BIT];
        OFS_MEMCTL: ext_bus_disable_d = HWDATA[EXT_BUS_DISABLE_BIT];
        default:    ;
      endcase
    end
    unique case (st_q)
      ST_IDLE: begin
        if (HSEL && HTRANS[1] && HREADY) begin
          addr_d = HADDR[OFS_W-1:0];
          if (HWRITE) begin
            wr_pend_d = 1'b1;
          end else begin
            // One wait state so a read right after a write sees it
            st_d    = ST_RD;
            ready_d = 1'b0;
          end
        end
      end
      ST_RD: begin
        st_d = ST_IDLE;
        case (addr_q)
          OFS_H_PIN:  rdata_d = widen(PORT_H_PIN_IN);
          OFS_H_LAT:  rdata_d = widen(lat_h_q);
          OFS_H_DIR:  rdata_d = widen(dir_h_q);
          OFS_J_PIN:  rdata_d = widen(PORT_J_PIN_IN);
          OFS_J_LAT:  rdata_d = widen(lat_j_q);
          OFS_J_DIR:  rdata_d = widen(dir_j_q);
          OFS_PU_CTL: rdata_d = widen({2'b00, pu_q, 5'b0_0000});
          OFS_MEMCTL: rdata_d = widen({ext_bus_disable_q, 7'b000_0000});
          default:    rdata_d = 32'h0000_0000;
        endcase
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st_q      <= ST_IDLE;
      addr_q    <= 8'h00;
      wr_pend_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      ready_q   <= 1'b1;
      lat_h_q   <= LAT_RST;
      dir_h_q   <= DIR_RST;
      lat_j_q   <= LAT_RST;
      dir_j_q   <= DIR_RST;
      pu_q      <= PU_RST;
      ext_bus_disable_q   <= EXT_BUS_DISABLE_RST;
    end else begin
      st_q      <= st_d;
      addr_q    <= addr_d;
      wr_pend_q <= wr_pend_d;
      rdata_q   <= rdata_d;
      ready_q   <= ready_d;
      lat_h_q   <= lat_h_d;
      dir_h_q   <= dir_h_d;
      lat_j_q   <= lat_j_d;
      dir_j_q   <= dir_j_d;
      pu_q      <= pu_d;
      ext_bus_disable_q   <= ext_bus_disable_d;
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_comb begin
    // Address bits 16..19 on pins 0..3
    h_pins_d = pin_mux(emi_en ? H_ADDR_MASK : NONE_MASK,
                       {{(PORT_W-HADDR_PIN){1'b0}}, HIGH_ADDRESS_IN}, lat_h_q, dir_h_q);
    j_pins_d = pin_mux(emi_en ? ALL_MASK : NONE_MASK,
                       BUS_CTRL_IN, lat_j_q, dir_j_q);
    pullup_d = {PORT_W{pu_q}} & j_pins_d.oe_n;
    bus_en_d = emi_en;
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      h_pins_q <= '{data: LAT_RST, oe_n: DIR_RST};
      j_pins_q <= '{data: LAT_RST, oe_n: DIR_RST};
      pullup_q <= NONE_MASK;
      bus_en_q <= ~EXT_BUS_DISABLE_RST;
    end else begin
      h_pins_q <= h_pins_d;
      j_pins_q <= j_pins_d;
      pullup_q <= pullup_d;
      bus_en_q <= bus_en_d;
    end
  end

  assign HRDATA           = rdata_q;
  assign HREADYOUT        = ready_q;
  // Only OKAY; unmapped reads give zero
  assign HRESP            = 1'b0;
  assign PORT_H_PINS      = h_pins_q;
  assign PORT_J_PINS      = j_pins_q;
  assign PORT_J_PULLUP_EN = pullup_q;
  assign EXT_BUS_ENABLE   = bus_en_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  logic [1:0] cfg_seen_q;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_seen_q <= 2'b00;
    end else begin
      cfg_seen_q <= cfg_seen_q | {wr_pend_q && addr_q == OFS_PU_CTL,
                                  wr_pend_q && addr_q == OFS_J_DIR};
    end
  end

  property p_h_gpio;
    1'b1 |=> PORT_H_PINS.data[7:4] == $past(lat_h_q[7:4]) && PORT_H_PINS.oe_n[7:4] == $past(dir_h_q[7:4]);
  endproperty
  a_h_gpio: assert property (p_h_gpio) else $error("port H upper pins wrong");

  property p_h_lo_gpio;
    ext_bus_disable_q |=> PORT_H_PINS.data[3:0] == $past(lat_h_q[3:0]) && PORT_H_PINS.oe_n[3:0] == $past(dir_h_q[3:0]);
  endproperty
  a_h_lo_gpio: assert property (p_h_lo_gpio) else $error("port H lower pins wrong");

  property p_pin_read;
    st_q == ST_RD && addr_q == OFS_H_PIN |=> HREADYOUT && HRDATA == widen($past(PORT_H_PIN_IN));
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

  property p_h_addr;
    emi_en |=> PORT_H_PINS.data[3:0] == $past(HIGH_ADDRESS_IN) && PORT_H_PINS.oe_n[3:0] == 4'h0;
  endproperty
  a_h_addr: assert property (p_h_addr) else $error("high address not driven");

  property p_dir_kept;
    emi_en && !wr_pend_q |=> $stable(dir_h_q);
  endproperty
  a_dir_kept: assert property (p_dir_kept) else $error("direction altered");

  property p_j_gpio;
    ext_bus_disable_q |=> PORT_J_PINS.data == $past(lat_j_q) && PORT_J_PINS.oe_n == $past(dir_j_q);
  endproperty
  a_j_gpio: assert property (p_j_gpio) else $error("port J gpio wrong");

  property p_j_rst_in;
    !cfg_seen_q[0] |-> dir_j_q == DIR_RST;
  endproperty
  a_j_rst_in: assert property (p_j_rst_in) else $error("port J not input");

  property p_pu_off;
    !pu_q |=> PORT_J_PULLUP_EN == NONE_MASK;
  endproperty
  a_pu_off: assert property (p_pu_off) else $error("pull-up on while off");

  property p_pu_out;
    (PORT_J_PULLUP_EN & ~PORT_J_PINS.oe_n) == NONE_MASK;
  endproperty
  a_pu_out: assert property (p_pu_out) else $error("pull-up on driven pin");

  property p_pu_rst;
    !cfg_seen_q[1] |-> !pu_q && PORT_J_PULLUP_EN == NONE_MASK;
  endproperty
  a_pu_rst: assert property (p_pu_rst) else $error("pull-up on before enable");

  property p_j_bus;
    !ext_bus_disable_q |=> PORT_J_PINS.oe_n == NONE_MASK && EXT_BUS_ENABLE;
  endproperty
  a_j_bus: assert property (p_j_bus) else $error("port J not forced out");

  property p_j_map;
    !ext_bus_disable_q |=> PORT_J_PINS.data == $past(BUS_CTRL_IN);
  endproperty
  a_j_map: assert property (p_j_map) else $error("strobe mapping wrong");

  property p_lat_wr;
    wr_pend_q && addr_q == OFS_H_PIN |=> lat_h_q == $past(HWDATA[7:0]);
  endproperty
  a_lat_wr: assert property (p_lat_wr) else $error("pin write missed latch");

  property p_ext_bus_disable_wr;
    wr_pend_q && addr_q == OFS_MEMCTL && !HWDATA[EXT_BUS_DISABLE_BIT] |=> ##1 EXT_BUS_ENABLE;
  endproperty
  a_ext_bus_disable_wr: assert property (p_ext_bus_disable_wr) else $error("bus not enabled");

  c_read:  cover property (st_q == ST_RD ##1 HREADYOUT);
  c_write: cover property (wr_pend_q && addr_q == OFS_J_LAT);
  c_bus:   cover property (ext_bus_disable_q ##1 !ext_bus_disable_q ##1 EXT_BUS_ENABLE);
  c_pu:    cover property (PORT_J_PULLUP_EN != NONE_MASK);

endmodule

/* sim/gpb_pin_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Far-side pin load
// ----------------------------------------
module gpb_pin_model (
  input  wire logic               clk,
  input  wire gpb_pkg::gpb_pins_t pins,
  input  wire logic [7:0]         pull_en,
  input  wire logic [7:0]         ext_oe,
  input  wire logic [7:0]         ext_val,
  output logic      [7:0]         level
);
  import gpb_pkg::*;
  logic [7:0] float_q = 8'h55;
  logic [7:0] float_d;

  // Floating lines toggle so a stale value never passes
  always_comb begin
    float_d = ~float_q;
  end

  always @(posedge clk) begin
    float_q <= float_d;
  end

  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      if (!pins.oe_n[i]) begin
        level[i] = pins.data[i];
      end else if (ext_oe[i]) begin
        level[i] = ext_val[i];
      end else if (pull_en[i]) begin
        level[i] = 1'b1;
      end else begin
        level[i] = float_q[i];
      end
    end
  end
endmodule

/* sim/tb.sv */
`timescale 1ns/100ps
module tb;
  import gpb_pkg::*;
  logic        SYS_CLK = 1'b0;
  logic        NRST    = 1'b0;
  logic        HSEL    = 1'b0;
  logic [31:0] HADDR   = 32'h0000_0000;
  logic [1:0]  HTRANS  = 2'h0;
  logic        HWRITE  = 1'b0;
  logic [31:0] HWDATA  = 32'h0000_0000;
  logic [31:0] HRDATA;
  logic        HREADYOUT;
  logic        HRESP;
  logic [7:0]  h_lvl;
  logic [7:0]  j_lvl;
  logic [7:0]  pull_j;
  logic        ext_bus;
  logic [3:0]  hi_addr = 4'h0;
  logic [7:0]  ctrl    = 8'h00;
  logic [7:0]  h_ext   = 8'h3C;
  gpb_pins_t   h_pins;
  gpb_pins_t   j_pins;
  int          fail_count = 0;
  int          num_checks = 0;

  always #25 SYS_CLK = ~SYS_CLK;

  gpb_ports dut_u (.SYS_CLK(SYS_CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PORT_H_PIN_IN(h_lvl), .PORT_H_PINS(h_pins),
    .PORT_J_PIN_IN(j_lvl), .PORT_J_PINS(j_pins), .PORT_J_PULLUP_EN(pull_j),
    .HIGH_ADDRESS_IN(hi_addr), .BUS_CTRL_IN(ctrl), .EXT_BUS_ENABLE(ext_bus));
  gpb_pin_model h_mdl (.clk(SYS_CLK), .pins(h_pins), .pull_en(8'h00), .ext_oe(8'hFF),
    .ext_val(h_ext), .level(h_lvl));
  gpb_pin_model j_mdl (.clk(SYS_CLK), .pins(j_pins), .pull_en(pull_j), .ext_oe(8'h00),
    .ext_val(8'h00), .level(j_lvl));

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Entered just after a rising edge; returns at the edge ending the data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] wd, output logic [31:0] rd);
    HSEL   <= 1'b1;
    HADDR  <= {24'h0000_00, a};
    HTRANS <= 2'h2;
    HWRITE <= w;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0000_00, wd};
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] dummy;
    bus(a, 1'b1, d, dummy);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(a, 1'b0, 8'h00, d);
    check(nm, exp, d);
    check({nm, " resp"}, 32'h0000_0000, {31'h0000_0000, HRESP});
  endtask

  task automatic pins(input string nm, input logic [7:0] hd, input logic [7:0] ho, input logic [7:0] jd,
                      input logic [7:0] jo, input logic [7:0] pu, input logic eb);
    repeat (2) @(posedge SYS_CLK);
    check({nm, " port h"}, {16'h0000, hd, ho}, {16'h0000, h_pins});
    check({nm, " port j"}, {16'h0000, jd, jo}, {16'h0000, j_pins});
    check({nm, " pullup"}, {24'h0000_00, pu}, {24'h0000_00, pull_j});
    check({nm, " bus en"}, {31'h0000_0000, eb}, {31'h0000_0000, ext_bus});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (4000) @(posedge SYS_CLK);
    fail_count++;
    results();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(posedge SYS_CLK);
    rchk("h lat rst", OFS_H_LAT, 32'h0000_0000);
    rchk("h dir rst", OFS_H_DIR, 32'h0000_00FF);
    rchk("j lat rst", OFS_J_LAT, 32'h0000_0000);
    rchk("j dir rst", OFS_J_DIR, 32'h0000_00FF);
    rchk("pu rst", OFS_PU_CTL, 32'h0000_0000);
    rchk("mem rst", OFS_MEMCTL, 32'h0000_0080);
    rchk("h pin in", OFS_H_PIN, 32'h0000_003C);
    pins("rst", 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 1'b0);
    $display("test reset done");
    wr(OFS_H_LAT, 8'hFF);
    wr(OFS_H_PIN, 8'h5A);
    wr(OFS_H_DIR, 8'hC3);
    rchk("h lat", OFS_H_LAT, 32'h0000_005A);
    pins("h gpio", 8'h5A, 8'hC3, 8'h00, 8'hFF, 8'h00, 1'b0);
    rchk("h pin mix", OFS_H_PIN, 32'h0000_0018);
    wr(8'h20, 8'hFF);
    rchk("unmapped", 8'h20, 32'h0000_0000);
    $display("test port h done");
    wr(OFS_J_LAT, 8'hFF);
    wr(OFS_J_PIN, 8'hA5);
    rchk("j lat", OFS_J_LAT, 32'h0000_00A5);
    wr(OFS_J_DIR, 8'h0F);
    wr(OFS_PU_CTL, 8'h20);
    pins("j pull", 8'h5A, 8'hC3, 8'hA5, 8'h0F, 8'h0F, 1'b0);
    rchk("j pin", OFS_J_PIN, 32'h0000_00AF);
    wr(OFS_PU_CTL, 8'hDF);
    pins("j pull off", 8'h5A, 8'hC3, 8'hA5, 8'h0F, 8'h00, 1'b0);
    wr(OFS_PU_CTL, 8'h20);
    $display("test port j done");
    hi_addr <= 4'h6;
    ctrl    <= 8'h96;
    wr(OFS_MEMCTL, 8'h7F);
    pins("bus on", 8'h56, 8'hC0, 8'h96, 8'h00, 8'h00, 1'b1);
    rchk("h dir kept", OFS_H_DIR, 32'h0000_00C3);
    rchk("j dir kept", OFS_J_DIR, 32'h0000_000F);
    for (int i = 0; i < 8; i++) begin
      ctrl    <= 8'h01 << i;
      hi_addr <= i[3:0];
      pins("walk", {4'h5, i[3:0]}, 8'hC0, 8'h01 << i, 8'h00, 8'h00, 1'b1);
    end
    rchk("h pin bus", OFS_H_PIN, 32'h0000_0017);
    wr(OFS_MEMCTL, 8'h80);
    pins("bus off", 8'h5A, 8'hC3, 8'hA5, 8'h0F, 8'h0F, 1'b0);
    $display("test bus done");
    NRST <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(posedge SYS_CLK);
    rchk("h dir rst2", OFS_H_DIR, 32'h0000_00FF);
    rchk("pu rst2", OFS_PU_CTL, 32'h0000_0000);
    pins("rst2", 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 1'b0);
    $display("test reset again done");
    results();
  end
endmodule
